// ---- logic/fbank_edge.sv ----
// clock pin edge detector, one clock pulse per edge
module fbank_edge (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic pin_in,
   output logic rise_out,
   output logic fall_out
);

   logic prev_reg;
   logic valid_reg;

   // first sample after reset only primes the history
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prev_reg <= fbank_pkg::FBANK_CLK_RST;
         valid_reg <= 1'b0;
      end else begin
         prev_reg <= pin_in;
         valid_reg <= 1'b1;
      end
   end

   assign rise_out = valid_reg & pin_in & ~prev_reg;
   assign fall_out = valid_reg & ~pin_in & prev_reg;

endmodule // fbank_edge

// ---- logic/fbank_latch.sv ----
// gated latch bank, set-reset or data form
module fbank_latch #(
   parameter int N = fbank_pkg::FBANK_N_DEF,
   parameter fbank_pkg::fbank_latch_mode_t MODE = fbank_pkg::FBANK_D
) (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire fbank_pkg::fbank_ctrl_t ctrl_in,
   input wire logic [N-1:0] a_in,
   input wire logic [N-1:0] b_in,
   output logic [N-1:0] q_out,
   output logic [N-1:0] qn_out
);

   if (N < 1) begin : g_width_chk
      $error("bank width must be at least 1");
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q_out <= {N{fbank_pkg::FBANK_RST_Q}};
         qn_out <= {N{fbank_pkg::FBANK_RST_QN}};
      end else if (!ctrl_in.preset_n && !ctrl_in.async_clear_n) begin
         q_out <= '1;
         qn_out <= '1;
      end else if (!ctrl_in.async_clear_n) begin
         q_out <= '0;
         qn_out <= '1;
      end else if (!ctrl_in.preset_n) begin
         q_out <= '1;
         qn_out <= '0;
      end else if (ctrl_in.clk) begin
         if (MODE == fbank_pkg::FBANK_D) begin
            q_out <= a_in;
            qn_out <= ~a_in;
         end else begin
            // set and reset both high give 1 on both outputs
            q_out <= (q_out & ~b_in) | a_in;
            qn_out <= (qn_out & ~a_in) | b_in;
         end
      end
   end

   gate_freeze_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (!ctrl_in.clk && ctrl_in.preset_n && ctrl_in.async_clear_n) |=> $stable(q_out))
      else $error("latch changed while gate low");

endmodule // fbank_latch

// ---- logic/fbank_pkg.sv ----
// constants, types and helpers shared by the flip-flop bank design
// What this block does
// - bank width is a parameter; every bit has own data, true and inverted output
// - one preset, one clear and one clock input are shared by the whole bank
// - each dual-edge bank has one rising-edge enable and one falling-edge enable shared by its bits
// - clear low with preset high forces every bit to 0, inverse to 1
// - preset low with clear high forces every bit to 1, inverse to 0
// - preset and clear both low drive true and inverted outputs both to 1
// - dual-edge data bank holds its bits while both edge enables are low
// - dual-edge data bank loads data on an enabled rising clock edge
// - dual-edge data bank loads data on an enabled falling clock edge
// - with a steady clock and controls inactive every flip-flop bit holds its value
// - dual-edge toggle bank, enabled rising edge, j 0 k 1 resets bit
// - dual-edge toggle bank, enabled rising edge, j 1 k 0 sets bit
// - dual-edge toggle bank, enabled rising edge, j and k 1 toggles bit
// - dual-edge toggle bank, enabled rising edge, j and k 0 holds bit
// - enabled falling edge applies the same j-k action as a rising one
// - a gated set-reset latch and a gated data latch are also provided
// - single-edge toggle bank changes only on the falling clock edge
// - single-edge data bank loads only on the rising clock edge
// - gated latch follows input while gate high, freezes when gate falls
package fbank_pkg;

   localparam int FBANK_N_DEF = 2;
   localparam logic FBANK_RST_Q = 1'b0;
   localparam logic FBANK_RST_QN = 1'b1;
   localparam logic FBANK_CLK_RST = 1'b0;

   // index of each edge bank in the control array
   localparam int FBANK_RD = 0;
   localparam int FBANK_FK = 1;
   localparam int FBANK_DD = 2;
   localparam int FBANK_DK = 3;
   localparam int FBANK_NBANK = 4;

   typedef enum logic {
      FBANK_SR = 1'b0,
      FBANK_D = 1'b1
   } fbank_latch_mode_t;

   // shared controls of one bank; clk is the gate for latches
   typedef struct packed {
      logic preset_n;
      logic async_clear_n;
      logic clk;
      logic rise_edge_enable;
      logic fall_edge_enable;
   } fbank_ctrl_t;

   // j-k step of one bit
   function automatic logic fbank_jk(input logic q, input logic j, input logic k);
      logic r;
      r = (j & ~q) | (~k & q);
      return r;
   endfunction

endpackage : fbank_pkg

// ---- logic/fbank_top.sv ----
// bank of flip-flop and latch primitives on one system clock
module fbank_top #(
   parameter int N = fbank_pkg::FBANK_N_DEF
) (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire fbank_pkg::fbank_ctrl_t rd_ctrl_in,
   input wire logic [N-1:0] rd_d_in,
   output logic [N-1:0] rd_q_out,
   output logic [N-1:0] rd_qn_out,
   input wire fbank_pkg::fbank_ctrl_t fk_ctrl_in,
   input wire logic [N-1:0] fk_j_in,
   input wire logic [N-1:0] fk_k_in,
   output logic [N-1:0] fk_q_out,
   output logic [N-1:0] fk_qn_out,
   input wire fbank_pkg::fbank_ctrl_t dd_ctrl_in,
   input wire logic [N-1:0] dd_d_in,
   output logic [N-1:0] dd_q_out,
   output logic [N-1:0] dd_qn_out,
   input wire fbank_pkg::fbank_ctrl_t dk_ctrl_in,
   input wire logic [N-1:0] dk_j_in,
   input wire logic [N-1:0] dk_k_in,
   output logic [N-1:0] dk_q_out,
   output logic [N-1:0] dk_qn_out,
   input wire fbank_pkg::fbank_ctrl_t sl_ctrl_in,
   input wire logic [N-1:0] sl_s_in,
   input wire logic [N-1:0] sl_r_in,
   output logic [N-1:0] sl_q_out,
   output logic [N-1:0] sl_qn_out,
   input wire fbank_pkg::fbank_ctrl_t tl_ctrl_in,
   input wire logic [N-1:0] tl_d_in,
   output logic [N-1:0] tl_q_out,
   output logic [N-1:0] tl_qn_out
);

   if (N < 1) begin : g_width_chk
      $error("bank width must be at least 1");
   end

   fbank_pkg::fbank_ctrl_t ctl [fbank_pkg::FBANK_NBANK];
   logic [fbank_pkg::FBANK_NBANK-1:0] rise_ev;
   logic [fbank_pkg::FBANK_NBANK-1:0] fall_ev;
   logic [N-1:0] rd_q_reg;
   logic [N-1:0] rd_qn_reg;
   logic [N-1:0] fk_q_reg;
   logic [N-1:0] fk_qn_reg;
   logic [N-1:0] dd_q_reg;
   logic [N-1:0] dd_qn_reg;
   logic [N-1:0] dk_q_reg;
   logic [N-1:0] dk_qn_reg;
   logic [N-1:0] fk_next;
   logic [N-1:0] dk_next;
   logic dd_load;
   logic dk_load;

   // one shared control group per bank
   assign ctl[fbank_pkg::FBANK_RD] = rd_ctrl_in;
   assign ctl[fbank_pkg::FBANK_FK] = fk_ctrl_in;
   assign ctl[fbank_pkg::FBANK_DD] = dd_ctrl_in;
   assign ctl[fbank_pkg::FBANK_DK] = dk_ctrl_in;

   // clock pin edges of each edge bank
   for (genvar b = 0; b < fbank_pkg::FBANK_NBANK; b++) begin : g_edge
      fbank_edge u_edge (
         .mclk_in(mclk_in),
         .rstn_in(rstn_in),
         .pin_in(ctl[b].clk),
         .rise_out(rise_ev[b]),
         .fall_out(fall_ev[b])
      );
   end

   // per-bit j-k next values
   for (genvar i = 0; i < N; i++) begin : g_jk
      assign fk_next[i] = fbank_pkg::fbank_jk(fk_q_reg[i], fk_j_in[i], fk_k_in[i]);
      assign dk_next[i] = fbank_pkg::fbank_jk(dk_q_reg[i], dk_j_in[i], dk_k_in[i]);
   end

   // enabled edges of the dual-edge banks
   assign dd_load = (rise_ev[fbank_pkg::FBANK_DD] & dd_ctrl_in.rise_edge_enable)
      | (fall_ev[fbank_pkg::FBANK_DD] & dd_ctrl_in.fall_edge_enable);
   assign dk_load = (rise_ev[fbank_pkg::FBANK_DK] & dk_ctrl_in.rise_edge_enable)
      | (fall_ev[fbank_pkg::FBANK_DK] & dk_ctrl_in.fall_edge_enable);

   // rising-edge data bank
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_q_reg <= {N{fbank_pkg::FBANK_RST_Q}};
         rd_qn_reg <= {N{fbank_pkg::FBANK_RST_QN}};
      end else if (!rd_ctrl_in.preset_n && !rd_ctrl_in.async_clear_n) begin
         rd_q_reg <= '1;
         rd_qn_reg <= '1;
      end else if (!rd_ctrl_in.async_clear_n) begin
         rd_q_reg <= '0;
         rd_qn_reg <= '1;
      end else if (!rd_ctrl_in.preset_n) begin
         rd_q_reg <= '1;
         rd_qn_reg <= '0;
      end else if (rise_ev[fbank_pkg::FBANK_RD]) begin
         rd_q_reg <= rd_d_in;
         rd_qn_reg <= ~rd_d_in;
      end
   end

   // falling-edge j-k bank
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         fk_q_reg <= {N{fbank_pkg::FBANK_RST_Q}};
         fk_qn_reg <= {N{fbank_pkg::FBANK_RST_QN}};
      end else if (!fk_ctrl_in.preset_n && !fk_ctrl_in.async_clear_n) begin
         fk_q_reg <= '1;
         fk_qn_reg <= '1;
      end else if (!fk_ctrl_in.async_clear_n) begin
         fk_q_reg <= '0;
         fk_qn_reg <= '1;
      end else if (!fk_ctrl_in.preset_n) begin
         fk_q_reg <= '1;
         fk_qn_reg <= '0;
      end else if (fall_ev[fbank_pkg::FBANK_FK]) begin
         fk_q_reg <= fk_next;
         fk_qn_reg <= ~fk_next;
      end
   end

   // dual-edge data bank
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dd_q_reg <= {N{fbank_pkg::FBANK_RST_Q}};
         dd_qn_reg <= {N{fbank_pkg::FBANK_RST_QN}};
      end else if (!dd_ctrl_in.preset_n && !dd_ctrl_in.async_clear_n) begin
         dd_q_reg <= '1;
         dd_qn_reg <= '1;
      end else if (!dd_ctrl_in.async_clear_n) begin
         dd_q_reg <= '0;
         dd_qn_reg <= '1;
      end else if (!dd_ctrl_in.preset_n) begin
         dd_q_reg <= '1;
         dd_qn_reg <= '0;
      end else if (dd_load) begin
         dd_q_reg <= dd_d_in;
         dd_qn_reg <= ~dd_d_in;
      end
   end

   // dual-edge j-k bank
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dk_q_reg <= {N{fbank_pkg::FBANK_RST_Q}};
         dk_qn_reg <= {N{fbank_pkg::FBANK_RST_QN}};
      end else if (!dk_ctrl_in.preset_n && !dk_ctrl_in.async_clear_n) begin
         dk_q_reg <= '1;
         dk_qn_reg <= '1;
      end else if (!dk_ctrl_in.async_clear_n) begin
         dk_q_reg <= '0;
         dk_qn_reg <= '1;
      end else if (!dk_ctrl_in.preset_n) begin
         dk_q_reg <= '1;
         dk_qn_reg <= '0;
      end else if (dk_load) begin
         dk_q_reg <= dk_next;
         dk_qn_reg <= ~dk_next;
      end
   end

   assign rd_q_out = rd_q_reg;
   assign rd_qn_out = rd_qn_reg;
   assign fk_q_out = fk_q_reg;
   assign fk_qn_out = fk_qn_reg;
   assign dd_q_out = dd_q_reg;
   assign dd_qn_out = dd_qn_reg;
   assign dk_q_out = dk_q_reg;
   assign dk_qn_out = dk_qn_reg;

   // gated latches
   fbank_latch #(
      .N(N),
      .MODE(fbank_pkg::FBANK_SR)
   ) u_sr_latch (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .ctrl_in(sl_ctrl_in),
      .a_in(sl_s_in),
      .b_in(sl_r_in),
      .q_out(sl_q_out),
      .qn_out(sl_qn_out)
   );

   fbank_latch #(
      .N(N),
      .MODE(fbank_pkg::FBANK_D)
   ) u_d_latch (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .ctrl_in(tl_ctrl_in),
      .a_in(tl_d_in),
      .b_in('0),
      .q_out(tl_q_out),
      .qn_out(tl_qn_out)
   );

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);

   clear_forces_zero_a: assert property (
      (dd_ctrl_in.preset_n && !dd_ctrl_in.async_clear_n)
      |=> (dd_q_out == '0) && (dd_qn_out == '1))
      else $error("clear did not force zero");

   preset_forces_one_a: assert property (
      (dk_ctrl_in.async_clear_n && !dk_ctrl_in.preset_n)
      |=> (dk_q_out == '1) && (dk_qn_out == '0))
      else $error("preset did not force one");

   both_low_ones_a: assert property (
      (!rd_ctrl_in.preset_n && !rd_ctrl_in.async_clear_n)
      |=> (rd_q_out == '1) && (rd_qn_out == '1))
      else $error("both low did not drive both outputs high");

   fall_bank_clear_a: assert property (
      (fk_ctrl_in.preset_n && !fk_ctrl_in.async_clear_n)
      |=> (fk_q_out == '0) && (fk_qn_out == '1))
      else $error("falling bank ignored clear");

   dual_idle_hold_a: assert property (
      (dd_ctrl_in.preset_n && dd_ctrl_in.async_clear_n
       && !dd_ctrl_in.rise_edge_enable && !dd_ctrl_in.fall_edge_enable)
      |=> $stable(dd_q_out) && $stable(dd_qn_out))
      else $error("dual data bank moved while disabled");

   dual_rise_load_a: assert property (
      (dd_ctrl_in.preset_n && dd_ctrl_in.async_clear_n
       && dd_ctrl_in.rise_edge_enable && dd_ctrl_in.clk && !$past(dd_ctrl_in.clk))
      |=> (dd_q_out == $past(dd_d_in)) && (dd_qn_out == ~$past(dd_d_in)))
      else $error("dual data bank missed rising load");

   dual_fall_load_a: assert property (
      (dd_ctrl_in.preset_n && dd_ctrl_in.async_clear_n
       && dd_ctrl_in.fall_edge_enable && !dd_ctrl_in.clk && $past(dd_ctrl_in.clk))
      |=> (dd_q_out == $past(dd_d_in)))
      else $error("dual data bank missed falling load");

   steady_clock_hold_a: assert property (
      (rd_ctrl_in.preset_n && rd_ctrl_in.async_clear_n && $stable(rd_ctrl_in.clk))
      |=> $stable(rd_q_out) && $stable(rd_qn_out))
      else $error("rising bank moved on steady clock");

   jk_toggle_a: assert property (
      (dk_ctrl_in.preset_n && dk_ctrl_in.async_clear_n && dk_load
       && (dk_j_in == '1) && (dk_k_in == '1))
      |=> (dk_q_out == ~$past(dk_q_out)))
      else $error("toggle bank did not invert");

   jk_reset_a: assert property (
      (dk_ctrl_in.preset_n && dk_ctrl_in.async_clear_n && dk_load
       && (dk_j_in == '0) && (dk_k_in == '1))
      |=> (dk_q_out == '0) && (dk_qn_out == '1))
      else $error("toggle bank did not reset");

   jk_set_a: assert property (
      (dk_ctrl_in.preset_n && dk_ctrl_in.async_clear_n && dk_load
       && (dk_j_in == '1) && (dk_k_in == '0))
      |=> (dk_q_out == '1) && (dk_qn_out == '0))
      else $error("toggle bank did not set");

   jk_hold_a: assert property (
      (dk_ctrl_in.preset_n && dk_ctrl_in.async_clear_n && dk_load
       && (dk_j_in == '0) && (dk_k_in == '0))
      |=> $stable(dk_q_out))
      else $error("toggle bank moved with j and k low");

   jk_fall_edge_a: assert property (
      (dk_ctrl_in.preset_n && dk_ctrl_in.async_clear_n
       && dk_ctrl_in.fall_edge_enable && fall_ev[fbank_pkg::FBANK_DK]
       && (dk_j_in == '1) && (dk_k_in == '1))
      |=> (dk_q_out == ~$past(dk_q_out)))
      else $error("falling edge did not toggle");

   fall_only_a: assert property (
      (fk_ctrl_in.preset_n && fk_ctrl_in.async_clear_n && !fall_ev[fbank_pkg::FBANK_FK])
      |=> $stable(fk_q_out))
      else $error("falling bank moved without falling edge");

   rise_only_a: assert property (
      (rd_ctrl_in.preset_n && rd_ctrl_in.async_clear_n && rise_ev[fbank_pkg::FBANK_RD])
      |=> (rd_q_out == $past(rd_d_in)))
      else $error("rising bank missed load");

   both_edges_a: assert property (
      (dd_ctrl_in.preset_n && dd_ctrl_in.async_clear_n
       && dd_ctrl_in.rise_edge_enable && dd_ctrl_in.fall_edge_enable
       && $changed(dd_ctrl_in.clk))
      |=> (dd_q_out == $past(dd_d_in)))
      else $error("dual bank missed an edge");

   rd_clear_zero_a: assert property (
      (rd_ctrl_in.preset_n && !rd_ctrl_in.async_clear_n)
      |=> (rd_q_out == '0) && (rd_qn_out == '1))
      else $error("rising bank ignored clear");

   fk_preset_one_a: assert property (
      (fk_ctrl_in.async_clear_n && !fk_ctrl_in.preset_n)
      |=> (fk_q_out == '1) && (fk_qn_out == '0))
      else $error("falling bank ignored preset");

   dd_both_low_a: assert property (
      (!dd_ctrl_in.preset_n && !dd_ctrl_in.async_clear_n)
      |=> (dd_q_out == '1) && (dd_qn_out == '1))
      else $error("dual data bank both low not both high");

   dk_both_low_a: assert property (
      (!dk_ctrl_in.preset_n && !dk_ctrl_in.async_clear_n)
      |=> (dk_q_out == '1) && (dk_qn_out == '1))
      else $error("dual toggle bank both low not both high");

   dk_clear_zero_a: assert property (
      (dk_ctrl_in.preset_n && !dk_ctrl_in.async_clear_n)
      |=> (dk_q_out == '0) && (dk_qn_out == '1))
      else $error("dual toggle bank ignored clear");

   dd_preset_one_a: assert property (
      (dd_ctrl_in.async_clear_n && !dd_ctrl_in.preset_n)
      |=> (dd_q_out == '1) && (dd_qn_out == '0))
      else $error("dual data bank ignored preset");

   fk_steady_hold_a: assert property (
      (fk_ctrl_in.preset_n && fk_ctrl_in.async_clear_n && $stable(fk_ctrl_in.clk))
      |=> $stable(fk_q_out) && $stable(fk_qn_out))
      else $error("falling bank moved on steady clock");

   rise_bank_fall_a: assert property (
      (rd_ctrl_in.preset_n && rd_ctrl_in.async_clear_n && fall_ev[fbank_pkg::FBANK_RD])
      |=> $stable(rd_q_out) && $stable(rd_qn_out))
      else $error("rising bank moved on falling edge");

   dk_idle_hold_a: assert property (
      (dk_ctrl_in.preset_n && dk_ctrl_in.async_clear_n
       && !dk_ctrl_in.rise_edge_enable && !dk_ctrl_in.fall_edge_enable)
      |=> $stable(dk_q_out) && $stable(dk_qn_out))
      else $error("dual toggle bank moved while disabled");

   sl_clear_zero_a: assert property (
      (sl_ctrl_in.preset_n && !sl_ctrl_in.async_clear_n)
      |=> (sl_q_out == '0) && (sl_qn_out == '1))
      else $error("set-reset latch ignored clear");

   tl_preset_one_a: assert property (
      (tl_ctrl_in.async_clear_n && !tl_ctrl_in.preset_n)
      |=> (tl_q_out == '1) && (tl_qn_out == '0))
      else $error("data latch ignored preset");

endmodule // fbank_top

// ---- verification/fbank_drv.sv ----
// model of the logic that drives the bank clock, gate and control pins
module fbank_drv (
   input wire logic mclk_in,
   output fbank_pkg::fbank_ctrl_t rd_ctrl_out,
   output fbank_pkg::fbank_ctrl_t fk_ctrl_out,
   output fbank_pkg::fbank_ctrl_t dd_ctrl_out,
   output fbank_pkg::fbank_ctrl_t dk_ctrl_out,
   output fbank_pkg::fbank_ctrl_t sl_ctrl_out,
   output fbank_pkg::fbank_ctrl_t tl_ctrl_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // one control set per bank, in package bank order, latches last
   fbank_pkg::fbank_ctrl_t ctl [6];

   initial begin
      for (int b = 0; b < 6; b++) begin
         ctl[b] = 5'h18;
      end
   end

   assign rd_ctrl_out = ctl[0];
   assign fk_ctrl_out = ctl[1];
   assign dd_ctrl_out = ctl[2];
   assign dk_ctrl_out = ctl[3];
   assign sl_ctrl_out = ctl[4];
   assign tl_ctrl_out = ctl[5];

   // preset, clear and edge enable levels of one bank
   task automatic set_ctl(input int b, input logic pre_n, input logic clr_n, input logic re, input logic fe);
      ctl[b].preset_n = pre_n;
      ctl[b].async_clear_n = clr_n;
      ctl[b].rise_edge_enable = re;
      ctl[b].fall_edge_enable = fe;
   endtask

   // clock or gate level, caller keeps it one cycle
   task automatic set_clk(input int b, input logic v);
      ctl[b].clk = v;
   endtask

   // new clock level, held for one full cycle
   task automatic edge_to(input int b, input logic v);
      ctl[b].clk = v;
      @(negedge mclk_in);
   endtask
endmodule // fbank_drv

// ---- verification/flip_flop_bank_primitives_tb.sv ----
// self-checking bench for the flip-flop and latch banks
module flip_flop_bank_primitives_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int N = 2;
   localparam int RD = fbank_pkg::FBANK_RD;
   localparam int FK = fbank_pkg::FBANK_FK;
   localparam int DD = fbank_pkg::FBANK_DD;
   localparam int DK = fbank_pkg::FBANK_DK;

   logic mclk_in;
   logic rstn_in;
   fbank_pkg::fbank_ctrl_t rd_c, fk_c, dd_c, dk_c, sl_c, tl_c;
   logic [N-1:0] rd_d, fk_j, fk_k, dd_d, dk_j, dk_k, sl_s, sl_r, tl_d;
   logic [N-1:0] rd_q, rd_qn, fk_q, fk_qn, dd_q, dd_qn, dk_q, dk_qn, sl_q, sl_qn, tl_q, tl_qn;
   logic [2*N-1:0] qq [6];
   int mismatches = 0;
   int samples_checked = 0;

   assign qq[0] = {rd_q, rd_qn};
   assign qq[1] = {fk_q, fk_qn};
   assign qq[2] = {dd_q, dd_qn};
   assign qq[3] = {dk_q, dk_qn};
   assign qq[4] = {sl_q, sl_qn};
   assign qq[5] = {tl_q, tl_qn};

   fbank_drv u_drv (.mclk_in(mclk_in), .rd_ctrl_out(rd_c), .fk_ctrl_out(fk_c), .dd_ctrl_out(dd_c),
      .dk_ctrl_out(dk_c), .sl_ctrl_out(sl_c), .tl_ctrl_out(tl_c));

   fbank_top #(.N(N)) u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
      .rd_ctrl_in(rd_c), .rd_d_in(rd_d), .rd_q_out(rd_q), .rd_qn_out(rd_qn),
      .fk_ctrl_in(fk_c), .fk_j_in(fk_j), .fk_k_in(fk_k), .fk_q_out(fk_q), .fk_qn_out(fk_qn),
      .dd_ctrl_in(dd_c), .dd_d_in(dd_d), .dd_q_out(dd_q), .dd_qn_out(dd_qn),
      .dk_ctrl_in(dk_c), .dk_j_in(dk_j), .dk_k_in(dk_k), .dk_q_out(dk_q), .dk_qn_out(dk_qn),
      .sl_ctrl_in(sl_c), .sl_s_in(sl_s), .sl_r_in(sl_r), .sl_q_out(sl_q), .sl_qn_out(sl_qn),
      .tl_ctrl_in(tl_c), .tl_d_in(tl_d), .tl_q_out(tl_q), .tl_qn_out(tl_qn));

   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end

   task automatic tick();
      @(negedge mclk_in);
   endtask

   task automatic chk(input string what, input logic [2*N-1:0] seen, input logic [2*N-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", what, exp, seen);
      end
   endtask

   // true and inverted outputs of a stored value
   function automatic logic [2*N-1:0] pr(input logic [N-1:0] q);
      return {q, ~q};
   endfunction

   // reference j-k step, hold, reset, set, toggle
   function automatic logic [N-1:0] jk_ref(input logic [N-1:0] q, input logic [N-1:0] j, input logic [N-1:0] k);
      logic [N-1:0] r;
      for (int i = 0; i < N; i++) begin
         case ({j[i], k[i]})
            2'h0: r[i] = q[i];
            2'h1: r[i] = 1'b0;
            2'h2: r[i] = 1'b1;
            default: r[i] = ~q[i];
         endcase
      end
      return r;
   endfunction

   task automatic t_reset();
      for (int b = 0; b < 6; b++) chk("reset", qq[b], 4'h3);
   endtask

   // both low, preset, then clear, with clocks and data fighting them
   task automatic t_pc();
      logic [N-1:0] dv;
      logic [2*N-1:0] ex;
      for (int m = 2; m >= 0; m--) begin
         dv = (m == 0) ? 2'h3 : 2'h0;
         ex = (m == 0) ? 4'h3 : ((m == 1) ? 4'hc : 4'hf);
         {rd_d, fk_j, dd_d, dk_j, sl_s, tl_d} = {6{dv}};
         {fk_k, dk_k, sl_r} = {3{~dv}};
         for (int b = 0; b < 6; b++) u_drv.set_ctl(b, m == 0, m == 1, 1'b1, 1'b1);
         for (int v = 1; v >= 0; v--) begin
            for (int b = 0; b < 6; b++) u_drv.set_clk(b, v[0]);
            tick();
            for (int b = 0; b < 6; b++) chk("preset clear", qq[b], ex);
         end
      end
      for (int b = 0; b < 6; b++) u_drv.set_ctl(b, 1'b1, 1'b1, 1'b0, 1'b0);
      tick();
      tick();
      for (int b = 0; b < 6; b++) chk("after release", qq[b], 4'h3);
   endtask

   task automatic t_rd();
      rd_d = 2'h2;
      u_drv.edge_to(RD, 1'b1);
      chk("rd rise", qq[0], pr(2'h2));
      rd_d = 2'h1;
      tick();
      tick();
      chk("rd steady", qq[0], pr(2'h2));
      u_drv.edge_to(RD, 1'b0);
      chk("rd fall", qq[0], pr(2'h2));
      u_drv.edge_to(RD, 1'b1);
      chk("rd rise again", qq[0], pr(2'h1));
   endtask

   task automatic t_fk();
      logic [N-1:0] e;
      e = '0;
      u_drv.set_ctl(FK, 1'b1, 1'b1, 1'b1, 1'b1);
      for (int c = 0; c < 4; c++) begin
         fk_j = {c[1], !c[1]};
         fk_k = {c[0], !c[0]};
         u_drv.edge_to(FK, 1'b1);
         chk("fk rise", qq[1], pr(e));
         u_drv.edge_to(FK, 1'b0);
         e = jk_ref(e, fk_j, fk_k);
         chk("fk fall", qq[1], pr(e));
      end
   endtask

   task automatic t_dd();
      logic [N-1:0] e;
      e = '0;
      for (int m = 0; m < 4; m++) begin
         u_drv.set_ctl(DD, 1'b1, 1'b1, m[1], m[0]);
         dd_d = ~e;
         u_drv.edge_to(DD, 1'b1);
         if (m[1]) e = ~e;
         chk("dd rise", qq[2], pr(e));
         dd_d = ~e;
         u_drv.edge_to(DD, 1'b0);
         if (m[0]) e = ~e;
         chk("dd fall", qq[2], pr(e));
      end
   endtask

   task automatic t_dk();
      logic [N-1:0] e;
      e = '0;
      for (int p = 0; p < 2; p++) begin
         u_drv.set_ctl(DK, 1'b1, 1'b1, p == 0, p == 1);
         for (int c = 0; c < 4; c++) begin
            dk_j = {c[1], !c[1]};
            dk_k = {c[0], !c[0]};
            u_drv.edge_to(DK, 1'b1);
            if (p == 0) e = jk_ref(e, dk_j, dk_k);
            chk("dk rise", qq[3], pr(e));
            u_drv.edge_to(DK, 1'b0);
            if (p == 1) e = jk_ref(e, dk_j, dk_k);
            chk("dk fall", qq[3], pr(e));
         end
      end
   endtask

   task automatic t_lat();
      tl_d = 2'h2;
      u_drv.edge_to(5, 1'b1);
      chk("tl open", qq[5], pr(2'h2));
      tl_d = 2'h1;
      tick();
      chk("tl follow", qq[5], pr(2'h1));
      tl_d = 2'h2;
      u_drv.edge_to(5, 1'b0);
      chk("tl frozen", qq[5], pr(2'h1));
      sl_s = 2'h3;
      sl_r = 2'h0;
      u_drv.edge_to(4, 1'b1);
      chk("sl set", qq[4], 4'hc);
      sl_s = 2'h0;
      sl_r = 2'h1;
      tick();
      chk("sl reset hold", qq[4], 4'h9);
      sl_s = 2'h2;
      sl_r = 2'h2;
      tick();
      chk("sl both", qq[4], 4'hb);
      sl_s = 2'h0;
      sl_r = 2'h3;
      u_drv.edge_to(4, 1'b0);
      chk("sl frozen", qq[4], 4'hb);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      rstn_in = 1'b0;
      {rd_d, fk_j, fk_k, dd_d, dk_j, dk_k, sl_s, sl_r, tl_d} = '0;
      repeat (2) tick();
      t_reset();
      rstn_in = 1'b1;
      repeat (2) tick();
      t_pc();
      t_rd();
      t_fk();
      t_dd();
      t_dk();
      t_lat();
      give_verdict();
   end

   initial begin
      #20us;
      mismatches++;
      give_verdict();
   end
endmodule // flip_flop_bank_primitives_tb
